// *** verilog/fsb_request_dev.sv ***
// Issuing processor end: takes requests on the reference clock and drives
// the two-sub-phase address transfer on the link bus clock.
// Assumes the host makes bus_clk and bus_reset_n, changing them off the rising edge.
`timescale 1ns/1ps

// Behaviour
// RQ1: Address sub-phase one, type sub-phase two. Code sends type with the address in sub-phase one, attributes in two.
// RQ2: Strobes mark both edges; low/high address groups.
// RQ3: Sample configuration lines at reset release.
// RQ4: Mask address bit 20 while mask input asserted.
// RQ5: Mask asserted only in real mode.
// RQ6: Mask asynchronous; valid by target ready.
// RQ7: Address strobe marks a valid new transaction.
// RQ8: Agents decode on address strobe activation.
// RQ9: Bus clock rising edge times all pins.
// RQ10: Agent unable to accept asserts block-next-request.
// RQ11: No new transaction while stall signalled.
module fsb_request_dev (
  // Reference clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link
  fsb_link_if.dev link,
  // Request port, reference domain
  input wire logic req_valid_i,
  input wire fsb_pkg::addr_t req_addr_i,
  input wire fsb_pkg::rtype_t req_type_i,
  input wire fsb_pkg::addr_t req_attr_i,
  output logic req_ready_o,
  // Local stall request, reference domain
  input wire logic stall_i,
  // Power-on configuration, bus clock domain
  output fsb_pkg::cfg_t cfg_o
);
  import fsb_pkg::*;

  typedef struct packed {
    logic ready;
    logic req_tgl;
    addr_t addr;
    rtype_t rtype;
    addr_t attr;
    logic stall;
    logic [2:0] ack_s;
    logic ack_ok;
  } ref_state_t;

  typedef struct packed {
    issue_state_t state;
    logic [2:0] req_s;
    logic req_ok;
    logic ack_tgl;
    logic [2:0] stall_s;
    logic stall_ok;
    logic [2:0] mask_s;
    logic mask_ok;
    logic rst_prev;
    cfg_t cfg;
    addr_t addr_o;
    logic addr_oe;
    rtype_t req_lines;
    logic ads;
    logic stb_lo;
    logic stb_hi;
    logic bnr_oe;
  } bus_state_t;

  ref_state_t r;
  ref_state_t next_r;
  bus_state_t b;
  bus_state_t next_b;

  // A synchronised change counts once the second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[2] == s[1]) ? s[2] : prev;
  endfunction : agree

  // Reference domain: hold one request until the bus side acknowledges it
  always_comb
  begin
    next_r = r;
    next_r.ack_s = {r.ack_s[1:0], b.ack_tgl};
    next_r.ack_ok = agree(r.ack_s, r.ack_ok);
    next_r.stall = stall_i;
    if (r.ready && req_valid_i)
    begin
      next_r.addr = req_addr_i;
      next_r.rtype = req_type_i;
      next_r.attr = req_attr_i;
      next_r.req_tgl = ~r.req_tgl;
    end
    next_r.ready = (next_r.req_tgl == next_r.ack_ok);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r <= '{ready: 1'b1, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  // Bus domain: every pin changes and is sampled on the bus clock rising edge
  always_comb
  begin
    next_b = b;
    next_b.req_s = {b.req_s[1:0], r.req_tgl};
    next_b.req_ok = agree(b.req_s, b.req_ok);
    next_b.stall_s = {b.stall_s[1:0], r.stall};
    next_b.stall_ok = agree(b.stall_s, b.stall_ok);
    // Mask is asynchronous to the bus clock
    next_b.mask_s = {b.mask_s[1:0], link.bit20_mask_input}; // see RQ6
    next_b.mask_ok = agree(b.mask_s, b.mask_ok);
    next_b.rst_prev = link.bus_reset_n;
    // Own inability to accept work is signalled as a stall
    next_b.bnr_oe = b.stall_ok; // see RQ10
    if (!link.bus_reset_n)
    begin
      next_b.state = ST_IDLE;
      next_b.addr_oe = 1'b0;
      next_b.ads = 1'b0;
      next_b.stb_lo = 1'b0;
      next_b.stb_hi = 1'b0;
    end
    else
    begin
      if (!b.rst_prev)
      begin
        next_b.cfg = link.addr[CFG_MSB:CFG_LSB]; // see RQ3
      end
      case (b.state)
        ST_IDLE:
        begin
          next_b.ads = 1'b0;
          next_b.addr_oe = 1'b0;
          // Pending request issues only while nobody stalls the bus
          if ((b.req_ok != b.ack_tgl) && !link.block_next_request) // see RQ11
          begin
            next_b.addr_o = r.addr;
            if (b.mask_ok)
            begin
              next_b.addr_o[MASK_BIT] = 1'b0; // see RQ4
            end
            next_b.addr_oe = 1'b1; // see RQ1
            next_b.req_lines = r.rtype;
            next_b.ads = 1'b1; // see RQ7
            // Rising strobe edges latch the address sub-phase
            next_b.stb_lo = 1'b1; // see RQ2
            next_b.stb_hi = 1'b1; // see RQ2
            next_b.state = ST_SUB1;
          end
        end
        ST_SUB1:
        begin
          next_b.addr_o = r.attr; // see RQ1
          next_b.ads = 1'b0;
          // Falling strobe edges latch the attribute sub-phase
          next_b.stb_lo = 1'b0; // see RQ2
          next_b.stb_hi = 1'b0; // see RQ2
          next_b.state = ST_SUB2;
        end
        ST_SUB2:
        begin
          next_b.addr_oe = 1'b0;
          next_b.ack_tgl = ~b.ack_tgl;
          next_b.state = ST_IDLE;
        end
        default:
        begin
          next_b.state = ST_IDLE;
          next_b.addr_oe = 1'b0;
          next_b.ads = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link.bus_clk or negedge rst_n_i) // see RQ9
  begin
    if (!rst_n_i)
    begin
      b <= '{state: ST_IDLE, default: '0};
    end
    else
    begin
      b <= next_b;
    end
  end

  assign req_ready_o = r.ready;
  assign cfg_o = b.cfg;
  assign link.addr_dev = b.addr_o;
  assign link.addr_dev_oe = b.addr_oe;
  assign link.req_lines = b.req_lines;
  assign link.addr_valid_strobe = b.ads;
  assign link.addr_strobe_low_group = b.stb_lo;
  assign link.addr_strobe_high_group = b.stb_hi;
  assign link.bnr_dev = b.bnr_oe;
  assign link.bnr_dev_oe = b.bnr_oe;
endmodule : fsb_request_dev

// *** verilog/fsb_pkg.sv ***
// Shared constants and types for the front-side bus address-phase ends.
// Assumes a 100 MHz reference clock and a link bus clock made by the host end.
package fsb_pkg;
  typedef logic [35:3] addr_t;
  typedef logic [4:0] rtype_t;
  typedef logic [4:0] cfg_t;

  // Address groups per strobe and the maskable bit
  localparam int LOW_GROUP_MSB = 16;
  localparam int HIGH_GROUP_LSB = 17;
  localparam int MASK_BIT = 20;

  // Address lines sampled as power-on configuration
  localparam int CFG_LSB = 27;
  localparam int CFG_MSB = 31;

  // Bus clock derived from the reference clock
  localparam int REF_PERIOD_NS = 10;
  localparam int BUS_PERIOD_NS = 160;
  localparam int BUS_HALF_CYCLES = BUS_PERIOD_NS / (2 * REF_PERIOD_NS);

  // Bus reset length and strap hold, in bus clock cycles
  localparam int RESET_BUS_CYCLES = 16;
  localparam int STRAP_HOLD_CYCLES = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SUB1 = 3'h2,
    ST_SUB2 = 3'h4
  } issue_state_t;
endpackage : fsb_pkg

// *** verilog/fsb_link_if.sv ***
// Link between the issuing processor end and the chipset end.
// Levels are positive logic: 1 means asserted. Shared pins resolve here.
`timescale 1ns/1ps
interface fsb_link_if;
  import fsb_pkg::*;
  logic bus_clk;
  logic bus_reset_n;
  addr_t addr_dev;
  logic addr_dev_oe;
  addr_t addr_host;
  logic addr_host_oe;
  addr_t addr;
  rtype_t req_lines;
  logic addr_valid_strobe;
  logic addr_strobe_low_group;
  logic addr_strobe_high_group;
  logic bnr_dev;
  logic bnr_dev_oe;
  logic bnr_host;
  logic bnr_host_oe;
  logic block_next_request;
  logic bit20_mask_input;

  // Undriven lines read as deasserted
  assign addr = addr_host_oe ? addr_host : (addr_dev_oe ? addr_dev : '0);
  assign block_next_request = (bnr_dev_oe & bnr_dev) | (bnr_host_oe & bnr_host);

  modport dev (
    input bus_clk, bus_reset_n, addr, block_next_request, bit20_mask_input,
    output addr_dev, addr_dev_oe, req_lines, addr_valid_strobe,
    output addr_strobe_low_group, addr_strobe_high_group, bnr_dev, bnr_dev_oe
  );
  modport host (
    output bus_clk, bus_reset_n, addr_host, addr_host_oe, bnr_host, bnr_host_oe,
    output bit20_mask_input,
    input addr, req_lines, addr_valid_strobe, addr_strobe_low_group,
    input addr_strobe_high_group, block_next_request
  );
endinterface : fsb_link_if

// *** verilog/fsb_request_host.sv ***
// Chipset end: makes the bus clock and bus reset, drives straps, the bit-20
// mask and stalls, and decodes transactions issued by the processor end.
// Assumes the processor end changes its pins on the bus clock rising edge.
`timescale 1ns/1ps
module fsb_request_host (
  // Reference clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link
  fsb_link_if.host link,
  // Control inputs, reference domain
  input wire fsb_pkg::addr_t straps_i,
  input wire logic mask20_i,
  input wire logic stall_i,
  // Decoded transactions
  output logic txn_valid_o,
  output fsb_pkg::addr_t txn_addr_o,
  output fsb_pkg::rtype_t txn_type_o,
  output fsb_pkg::addr_t txn_attr_o
);
  import fsb_pkg::*;

  typedef struct packed {
    logic [2:0] div;
    logic bclk;
    logic [4:0] rst_cnt;
    logic bus_rst_n;
    logic strap_oe;
    logic mask;
    logic bnr;
    logic [2:0] lo_s;
    logic [2:0] hi_s;
    logic [2:0] ads_s;
    logic [2:0][32:0] addr_s;
    logic [2:0][4:0] req_s;
    logic lo_ok;
    logic hi_ok;
    logic ads_seen;
    logic got_lo;
    logic got_hi;
    logic valid;
    addr_t addr;
    rtype_t rtype;
    addr_t attr;
    addr_t straps;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic fall;
  addr_t line;

  // Bus outputs other than the strap lines change as the bus clock falls, stable at its rising edge
  assign fall = s.bclk && (s.div == 3'(BUS_HALF_CYCLES - 1)); // see RQ9
  assign line = s.addr_s[2];

  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    // Straps leave through a register so the link pins stand between clock edges
    next_s.straps = straps_i; // see RQ3
    next_s.div = (s.div == 3'(BUS_HALF_CYCLES - 1)) ? 3'h0 : s.div + 3'h1;
    if (s.div == 3'(BUS_HALF_CYCLES - 1))
    begin
      next_s.bclk = ~s.bclk;
    end
    if (fall)
    begin
      next_s.mask = mask20_i; // see RQ5
      next_s.bnr = stall_i; // see RQ10
      if (s.rst_cnt != 5'(RESET_BUS_CYCLES + STRAP_HOLD_CYCLES))
      begin
        next_s.rst_cnt = s.rst_cnt + 5'h1;
      end
      next_s.bus_rst_n = (next_s.rst_cnt >= 5'(RESET_BUS_CYCLES));
      next_s.strap_oe = (next_s.rst_cnt != 5'(RESET_BUS_CYCLES + STRAP_HOLD_CYCLES));
    end
    next_s.lo_s = {s.lo_s[1:0], link.addr_strobe_low_group};
    next_s.hi_s = {s.hi_s[1:0], link.addr_strobe_high_group};
    next_s.ads_s = {s.ads_s[1:0], link.addr_valid_strobe};
    next_s.addr_s = {s.addr_s[1:0], link.addr};
    next_s.req_s = {s.req_s[1:0], link.req_lines};
    // Low strobe edges: request lines and low address group
    if ((s.lo_s[2] == s.lo_s[1]) && (s.lo_s[2] != s.lo_ok)) // see RQ2
    begin
      next_s.lo_ok = s.lo_s[2];
      if (s.lo_s[2])
      begin
        next_s.addr[LOW_GROUP_MSB:3] = line[LOW_GROUP_MSB:3]; // see RQ1
        next_s.rtype = s.req_s[2];
        next_s.ads_seen = s.ads_s[2]; // see RQ7
      end
      else
      begin
        next_s.attr[LOW_GROUP_MSB:3] = line[LOW_GROUP_MSB:3]; // see RQ1
        next_s.got_lo = 1'b1;
      end
    end
    // High strobe edges: high address group
    if ((s.hi_s[2] == s.hi_s[1]) && (s.hi_s[2] != s.hi_ok)) // see RQ2
    begin
      next_s.hi_ok = s.hi_s[2];
      if (s.hi_s[2])
      begin
        next_s.addr[35:HIGH_GROUP_LSB] = line[35:HIGH_GROUP_LSB];
      end
      else
      begin
        next_s.attr[35:HIGH_GROUP_LSB] = line[35:HIGH_GROUP_LSB];
        next_s.got_hi = 1'b1;
      end
    end
    // Decode starts once a strobed transaction is complete
    if (s.got_lo && s.got_hi)
    begin
      next_s.got_lo = 1'b0;
      next_s.got_hi = 1'b0;
      next_s.ads_seen = 1'b0;
      next_s.valid = s.ads_seen; // see RQ8
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '{strap_oe: 1'b1, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.bus_clk = s.bclk;
  assign link.bus_reset_n = s.bus_rst_n;
  assign link.addr_host = s.straps;
  assign link.addr_host_oe = s.strap_oe;
  assign link.bit20_mask_input = s.mask;
  assign link.bnr_host = s.bnr;
  assign link.bnr_host_oe = s.bnr;
  assign txn_valid_o = s.valid;
  assign txn_addr_o = s.addr;
  assign txn_type_o = s.rtype;
  assign txn_attr_o = s.attr;
endmodule : fsb_request_host

// *** tb/fsb_link_properties.sv ***
// Checker for the link joining the issuing end and the chipset end.
// Assumes positive-logic link signals, all sampled on the link bus clock.
`timescale 1ns/1ps
module fsb_link_properties (
  // Link clock and reset
  input wire logic bus_clk,
  input wire logic bus_reset_n,
  // Link lines
  input wire fsb_pkg::addr_t addr,
  input wire logic addr_dev_oe,
  input wire logic addr_host_oe,
  input wire fsb_pkg::rtype_t req_lines,
  input wire logic addr_valid_strobe,
  input wire logic addr_strobe_low_group,
  input wire logic addr_strobe_high_group,
  input wire logic block_next_request,
  input wire logic bit20_mask_input
);
  import fsb_pkg::*;

  // Cycles the mask has been held, saturating so a settled mask is known
  logic [2:0] mask_cnt;

  always_ff @(posedge bus_clk or negedge bus_reset_n)
  begin
    if (!bus_reset_n)
      mask_cnt <= 3'h0;
    else if (!bit20_mask_input)
      mask_cnt <= 3'h0;
    else if (mask_cnt != 3'h7)
      mask_cnt <= mask_cnt + 3'h1;
  end

  default clocking cb @(posedge bus_clk);
  endclocking
  default disable iff (!bus_reset_n);

  sequence sub_one_s;
    addr_dev_oe && addr_strobe_low_group && addr_strobe_high_group;
  endsequence

  sequence sub_two_s;
    addr_dev_oe && !addr_valid_strobe && !addr_strobe_low_group && !addr_strobe_high_group;
  endsequence

  AST_SUBPHASES: assert property (
    addr_valid_strobe |-> sub_one_s ##1 sub_two_s ##1 !addr_dev_oe)
    else $error("address transfer sub-phases out of order");
  AST_SPACING: assert property (
    addr_valid_strobe |=> !addr_valid_strobe [*2])
    else $error("address strobe repeated too soon");
  AST_STROBE_START: assert property (
    $rose(addr_strobe_low_group) |-> addr_valid_strobe && addr_strobe_high_group)
    else $error("group strobes rose without a new transaction");
  AST_STALL: assert property (
    addr_valid_strobe |-> !$past(block_next_request))
    else $error("transaction issued during a bus stall");
  AST_MASK: assert property (
    addr_valid_strobe && mask_cnt == 3'h7 |-> !addr[MASK_BIT])
    else $error("address bit 20 not masked");
  AST_OE_START: assert property (
    $rose(addr_dev_oe) |-> addr_valid_strobe)
    else $error("address lines driven without address strobe");
  AST_TYPE_HELD: assert property (
    addr_valid_strobe |=> $stable(req_lines))
    else $error("request lines changed between sub-phases");
  AST_HOST_OFF: assert property (
    addr_valid_strobe |-> !addr_host_oe ##1 !addr_host_oe)
    else $error("host drives address lines during a transfer");
endmodule : fsb_link_properties

// *** tb/testbench.sv ***
// Bench joining both link ends: requests go in, decoded transactions come out.
// Assumes the host end makes the bus clock and the bus reset of the link.
`timescale 1ns/1ps
module testbench;
  import fsb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  addr_t req_addr = '0;
  rtype_t req_type = '0;
  addr_t req_attr = '0;
  logic req_ready;
  logic dev_stall = 1'b0;
  cfg_t cfg;
  addr_t straps = 33'h0A8001234;
  logic mask20 = 1'b0;
  logic host_stall = 1'b0;
  logic txn_valid;
  addr_t txn_addr;
  rtype_t txn_type;
  addr_t txn_attr;
  int fail_count = 0;
  int total_checks = 0;
  int txn_cnt = 0;
  int n0;
  int i;
  addr_t a;
  addr_t e;

  fsb_link_if link();

  fsb_request_dev u_fsb_request_dev (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(link),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .req_type_i(req_type),
    .req_attr_i(req_attr), .req_ready_o(req_ready), .stall_i(dev_stall), .cfg_o(cfg));

  fsb_request_host u_fsb_request_host (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(link),
    .straps_i(straps), .mask20_i(mask20), .stall_i(host_stall), .txn_valid_o(txn_valid),
    .txn_addr_o(txn_addr), .txn_type_o(txn_type), .txn_attr_o(txn_attr));

  fsb_link_properties u_fsb_link_properties (.bus_clk(link.bus_clk),
    .bus_reset_n(link.bus_reset_n), .addr(link.addr), .addr_dev_oe(link.addr_dev_oe),
    .addr_host_oe(link.addr_host_oe), .req_lines(link.req_lines),
    .addr_valid_strobe(link.addr_valid_strobe),
    .addr_strobe_low_group(link.addr_strobe_low_group),
    .addr_strobe_high_group(link.addr_strobe_high_group),
    .block_next_request(link.block_next_request), .bit20_mask_input(link.bit20_mask_input));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    if (txn_valid === 1'b1)
      txn_cnt++;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input addr_t ad, input rtype_t t, input addr_t b);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    req_valid <= 1'b1;
    req_addr <= ad;
    req_type <= t;
    req_attr <= b;
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask : send

  task automatic expect_txn(input addr_t ad, input rtype_t t, input addr_t b);
    int n;
    n = 0;
    while (txn_valid !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({35'h0, txn_valid}, 36'h1);
    check({3'h0, txn_addr}, {3'h0, ad});
    check({31'h0, txn_type}, {31'h0, t});
    check({3'h0, txn_attr}, {3'h0, b});
    @(posedge ref_clk);
  endtask : expect_txn

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 2000 && link.bus_reset_n !== 1'b1; i++)
      @(posedge ref_clk);
    repeat (60) @(posedge ref_clk);
    check({31'h0, cfg}, {31'h0, straps[CFG_MSB:CFG_LSB]});
    straps <= 33'h000000000;
    for (i = 0; i < 32; i++)
    begin
      a = 33'h123556788 ^ addr_t'(i << 12);
      send(a, rtype_t'(i), ~a);
      expect_txn(a, rtype_t'(i), ~a);
    end
    mask20 <= 1'b1;
    repeat (150) @(posedge ref_clk);
    // Address bit 20 set so that the mask has something to clear
    a[MASK_BIT] = 1'b1;
    e = a;
    e[MASK_BIT] = 1'b0;
    send(a, 5'h0A, ~a);
    expect_txn(e, 5'h0A, ~a);
    mask20 <= 1'b0;
    repeat (150) @(posedge ref_clk);
    for (i = 0; i < 2; i++)
    begin
      if (i == 0)
        host_stall <= 1'b1;
      else
        dev_stall <= 1'b1;
      repeat (100) @(posedge ref_clk);
      check({35'h0, link.block_next_request}, 36'h1);
      n0 = txn_cnt;
      send(a, 5'h15, ~a);
      repeat (300) @(posedge ref_clk);
      check(36'(txn_cnt), 36'(n0));
      host_stall <= 1'b0;
      dev_stall <= 1'b0;
      expect_txn(a, 5'h15, ~a);
    end
    // Second reset in mid-run with other straps
    rst_n <= 1'b0;
    straps <= 33'h0F0000000;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 2000 && link.bus_reset_n !== 1'b1; i++)
      @(posedge ref_clk);
    repeat (60) @(posedge ref_clk);
    check({31'h0, cfg}, {31'h0, straps[CFG_MSB:CFG_LSB]});
    send(a, 5'h03, ~a);
    expect_txn(a, 5'h03, ~a);
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
endmodule : testbench
